// *** clkrst_pkg.sv ***
// clock, reset and strap control package: shared constants and carriers
// assumes a 25 MHz core clock and a 32 kHz management clock
package clkrst_pkg;
    localparam int CORE_HZ = 25000000;
    localparam int MGMT_HZ = 32768;
    localparam int RESET_PULSE_MS = 128;
    // least time rounds up in management clock ticks
    localparam int RESET_PULSE_TICKS = (RESET_PULSE_MS * MGMT_HZ + 999) / 1000;
    localparam int STRAP_W = 12;
    localparam int MISC_LSB = 0;
    localparam int MISC_W = 3;
    localparam int SKEW_LSB = 3;
    localparam int SKEW_W = 3;
    localparam int RSVD_LSB = 6;
    localparam int RSVD_W = 6;
    localparam int DEBOUNCE_TICKS = 4;
    localparam int PCI_DIV_MAX = 256;
    localparam int PCI_IDLE_CYCLES = 1024;
    localparam int DEB_N = 5;
    localparam logic [7:0] KBD_RESET_CMD = 8'hfe;
    localparam logic [7:0] FAST_RESET_BIT = 8'h01;

    typedef enum logic [3:0] {
        MODE_FULL_ON = 4'h1,
        MODE_DOZE = 4'h2,
        MODE_SLEEP = 4'h4,
        MODE_DEEP = 4'h8
    } power_mode_t;

    typedef struct packed {
        logic switch_input;
        logic [1:0] resume_req;
        logic external_activity_in;
        logic modem_ring;
    } pm_inputs_t;

    typedef struct packed {
        logic system_mgmt_interrupt;
        logic primary_activity;
        logic secondary_activity;
        logic peer_bus_request;
    } peer_events_t;

    typedef struct packed {
        logic peer_bus_grant;
        logic coproc_irq13;
    } peer_info_t;
endpackage

// *** clock_reset_strap_control.sv ***
// clock distribution, reset pulse generation and strap capture of the system controller
// assumes main clock CORE_CLK, slow management clock and serial link clock from outside
//
// How it works
// R1 - processor, cache, link clocks share one frequency
// R2 - processor clock stops in sleep modes, restarts
// R3 - cache clock stops when idle or stop-clocked; here the stop clock request is ignored while PCI_SNOOP_ACTIVE is high
// R4 - pci clock is half processor clock
// R5 - idle pci clock slows by programmable divide
// R6 - management inputs debounced on slow clock
// R7 - refresh and timers tick from slow clock
// R8 - serial clock equals pci clock when awake
// R9 - deep sleep stops serial clock; pin restarts
// R10 - peer serializes its events inbound
// R11 - grant and irq13 sent outbound to peer
// R12 - master reset initialises every register, raises the reset pulse and the active-high reset outputs, and drives PCI_BUS_RESET_N low
// R13 - power-good mismatch pulses resets 128 ms
// R14 - warm init on shutdown, 64h, 92h
// R15 - strap bits hold misc and skew fields
// R16 - straps sampled on master reset rise
// R17 - address pins tristated until reset rises
// R18 - strap register read only, resampled next reset
// R19 - strap bits 11..6 reserved
// R20 - reset pulse timed in slow clock ticks
// R21 - gated clocks switch only while low
`timescale 1ns/1ps
module clock_reset_strap_control #(
    parameter int PCI_IDLE_LIMIT = clkrst_pkg::PCI_IDLE_CYCLES,
    parameter int RESET_TICKS = clkrst_pkg::RESET_PULSE_TICKS
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic SLOW_MGMT_CLOCK,
    input wire logic SERIAL_LINK_CLOCK_IN,
    input wire logic POWER_GOOD_IN,
    input wire clkrst_pkg::power_mode_t POWER_MODE,
    input wire logic MORE_STOP,
    input wire logic CACHE_IDLE,
    input wire logic STOP_CLOCK_REQ_N,
    input wire logic PCI_SNOOP_ACTIVE,
    input wire logic PCI_BUS_IDLE,
    input wire logic [7:0] PCI_DIV_SEL,
    input wire logic GENERAL_IO_PIN_2,
    input wire clkrst_pkg::pm_inputs_t PM_INPUTS_RAW,
    input wire logic SHUTDOWN_CYCLE,
    input wire logic IO_WRITE,
    input wire logic [15:0] IO_ADDR,
    input wire logic [7:0] IO_DATA,
    input wire clkrst_pkg::peer_info_t PEER_INFO,
    input wire logic SERIAL_IN_FROM_PEER,
    input wire logic [11:0] MEMORY_ADDRESS_PINS_IN,
    output logic [11:0] MEMORY_ADDRESS_PINS_OUT,
    output logic MEMORY_ADDRESS_PINS_OE_N,
    output logic PROCESSOR_CLOCK_OUT,
    output logic CACHE_CLOCK_OUT,
    output logic COMPANION_LINK_CLOCK,
    output logic PCI_BUS_CLOCK,
    output logic SERIAL_LINK_CLOCK,
    output logic SERIAL_OUT_TO_PEER,
    output clkrst_pkg::peer_events_t PEER_EVENTS,
    output clkrst_pkg::pm_inputs_t PM_INPUTS_CLEAN,
    output logic SLOW_TICK,
    output logic PROCESSOR_RESET_OUT,
    output logic PCI_BUS_RESET_N,
    output logic AT_BUS_RESET_OUT,
    output logic WARM_INIT_OUT,
    output logic [11:0] POWER_ON_STRAP_CONFIG
);
    initial begin
        if (PCI_IDLE_LIMIT < 1 || PCI_IDLE_LIMIT > 65535) $error("PCI_IDLE_LIMIT out of range");
        if (RESET_TICKS < 1 || RESET_TICKS > 65535) $error("RESET_TICKS out of range");
    end

    // ---------------- main clock derivation ----------------
    logic phase;
    logic gate_cpu;
    logic gate_cache;
    logic primary_wake;
    logic [1:0] wake_sync;
    logic cpu_stop_req;
    logic cache_stop_req;

    // phase is the common clock low/high; all derived clocks follow it
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) phase <= 1'b0;
        else phase <= ~phase; // R1
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) wake_sync <= 2'b00;
        else wake_sync <= {wake_sync[0], PM_INPUTS_CLEAN.switch_input | PM_INPUTS_CLEAN.external_activity_in};
    end
    assign primary_wake = wake_sync[1] | PEER_EVENTS.primary_activity;

    assign cpu_stop_req = ((POWER_MODE == clkrst_pkg::MODE_SLEEP) || (POWER_MODE == clkrst_pkg::MODE_DEEP)
                           || MORE_STOP) && !primary_wake; // R2
    assign cache_stop_req = CACHE_IDLE || (!STOP_CLOCK_REQ_N && !PCI_SNOOP_ACTIVE); // R3

    // gates change only on the edge that starts a low half
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            gate_cpu <= 1'b1;
            gate_cache <= 1'b1;
        end else if (phase) begin
            gate_cpu <= !cpu_stop_req; // R21
            gate_cache <= !cache_stop_req; // R21
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PROCESSOR_CLOCK_OUT <= 1'b0;
            CACHE_CLOCK_OUT <= 1'b0;
            COMPANION_LINK_CLOCK <= 1'b0;
        end else begin
            PROCESSOR_CLOCK_OUT <= ~phase & gate_cpu; // R2
            CACHE_CLOCK_OUT <= ~phase & gate_cache; // R3
            COMPANION_LINK_CLOCK <= ~phase; // R1
        end
    end

    // ---------------- pci clock and idle slowing ----------------
    logic [15:0] idle_cnt;
    logic slow_pci;
    logic [7:0] div_cnt;
    logic pci_clk_q;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            idle_cnt <= 16'h0000;
            slow_pci <= 1'b0;
        end else if (!PCI_BUS_IDLE) begin
            idle_cnt <= 16'h0000;
            slow_pci <= 1'b0;
        end else if (idle_cnt == 16'(PCI_IDLE_LIMIT - 1)) begin
            slow_pci <= 1'b1; // R5
        end else begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end

    // toggling once per processor period keeps pci at half the processor rate
    // divider value n gives a divide by n+1, so 8'hff reaches 256
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_cnt <= 8'h00;
            pci_clk_q <= 1'b0;
        end else if (phase) begin
            if (!slow_pci || div_cnt >= PCI_DIV_SEL) begin
                div_cnt <= 8'h00;
                pci_clk_q <= ~pci_clk_q; // R5
            end else begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end
    assign PCI_BUS_CLOCK = pci_clk_q; // R4

    // serial clock follows pci clock unless in deep sleep with GENERAL_IO_PIN_2 low
    logic serial_gate;
    logic [1:0] general_io_pin_2_sync;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) general_io_pin_2_sync <= 2'b00;
        else general_io_pin_2_sync <= {general_io_pin_2_sync[0], GENERAL_IO_PIN_2};
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) serial_gate <= 1'b1;
        else if (!pci_clk_q) serial_gate <= (POWER_MODE != clkrst_pkg::MODE_DEEP) || general_io_pin_2_sync[1]; // R9
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) SERIAL_LINK_CLOCK <= 1'b0;
        else SERIAL_LINK_CLOCK <= pci_clk_q & serial_gate; // R8
    end

    // ---------------- serial link, on the link clock ----------------
    // the link clock may stop in deep sleep; flags hold their last value then
    logic [1:0] link_rst_sync;
    logic [1:0] in_bit;
    logic [1:0] slot;
    logic [1:0] out_slot;
    logic [3:0] in_shift;
    clkrst_pkg::peer_events_t link_events;
    logic [1:0] info_s1;
    logic [1:0] info_s2;

    always_ff @(posedge SERIAL_LINK_CLOCK_IN or negedge RESETN) begin
        if (!RESETN) link_rst_sync <= 2'b00;
        else link_rst_sync <= {link_rst_sync[0], 1'b1};
    end

    always_ff @(posedge SERIAL_LINK_CLOCK_IN or negedge RESETN) begin
        if (!RESETN) begin
            info_s1 <= 2'b00;
            info_s2 <= 2'b00;
        end else begin
            info_s1 <= PEER_INFO;
            info_s2 <= info_s1;
        end
    end

    // four-slot frame in, two-slot frame out, slot counter shared
    always_ff @(posedge SERIAL_LINK_CLOCK_IN or negedge RESETN) begin
        if (!RESETN) begin
            slot <= 2'b00;
            in_shift <= 4'h0;
            link_events <= '0;
            in_bit <= 2'b00;
        end else if (link_rst_sync[1]) begin
            slot <= slot + 2'b01;
            in_bit <= {in_bit[0], SERIAL_IN_FROM_PEER};
            in_shift <= {in_shift[2:0], SERIAL_IN_FROM_PEER}; // R10
            if (slot == 2'b11) link_events <= {in_shift[2:0], SERIAL_IN_FROM_PEER}; // R10
        end
    end

    always_ff @(posedge SERIAL_LINK_CLOCK_IN or negedge RESETN) begin
        if (!RESETN) begin
            SERIAL_OUT_TO_PEER <= 1'b1;
            out_slot <= 2'b00;
        end else begin
            out_slot <= slot;
            SERIAL_OUT_TO_PEER <= slot[0] ? info_s2[0] : info_s2[1]; // R11
        end
    end

    // event levels cross back with two flip-flops each
    clkrst_pkg::peer_events_t ev_s1;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ev_s1 <= '0;
            PEER_EVENTS <= '0;
        end else begin
            ev_s1 <= link_events;
            PEER_EVENTS <= ev_s1;
        end
    end

    // ---------------- slow management clock ----------------
    logic [1:0] mgmt_rst_sync;
    logic slow_toggle;
    logic [2:0] tick_sync;

    always_ff @(posedge SLOW_MGMT_CLOCK or negedge RESETN) begin
        if (!RESETN) mgmt_rst_sync <= 2'b00;
        else mgmt_rst_sync <= {mgmt_rst_sync[0], 1'b1};
    end

    for (genvar i = 0; i < clkrst_pkg::DEB_N; i++) begin : g_deb
        debounce_cell #(
            .TICKS(clkrst_pkg::DEBOUNCE_TICKS)
        ) u_deb (
            .clk(SLOW_MGMT_CLOCK),
            .rst_n(RESETN),
            .raw(PM_INPUTS_RAW[i]),
            .clean(PM_INPUTS_CLEAN[i]) // R6
        );
    end

    // one slow tick per 32 kHz rising edge, handed to the core as a toggle
    always_ff @(posedge SLOW_MGMT_CLOCK or negedge RESETN) begin
        if (!RESETN) slow_toggle <= 1'b0;
        else slow_toggle <= ~slow_toggle; // R7
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) tick_sync <= 3'b000;
        else tick_sync <= {tick_sync[1:0], slow_toggle};
    end
    assign SLOW_TICK = tick_sync[2] ^ tick_sync[1]; // R7

    // ---------------- reset pulse generation ----------------
    logic [1:0] pg_sync;
    logic [15:0] rst_cnt;
    logic rst_active;
    logic mismatch;
    assign mismatch = pg_sync[1] != mgmt_rst_sync[1];

    always_ff @(posedge SLOW_MGMT_CLOCK or negedge RESETN) begin
        if (!RESETN) pg_sync <= 2'b00;
        else pg_sync <= {pg_sync[0], POWER_GOOD_IN};
    end

    // a fresh mismatch restarts the count, so the pulse is never cut short
    always_ff @(posedge SLOW_MGMT_CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rst_cnt <= 16'h0000;
            rst_active <= 1'b1; // R12
        end else if (mismatch) begin
            rst_cnt <= 16'h0000;
            rst_active <= 1'b1; // R13
        end else if (rst_active) begin
            if (rst_cnt == 16'(RESET_TICKS - 1)) rst_active <= 1'b0; // R20
            else rst_cnt <= rst_cnt + 16'h0001; // R20
        end
    end

    always_ff @(posedge SLOW_MGMT_CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            PROCESSOR_RESET_OUT <= 1'b1;
            PCI_BUS_RESET_N <= 1'b0;
            AT_BUS_RESET_OUT <= 1'b1;
        end else begin
            PROCESSOR_RESET_OUT <= rst_active; // R13
            PCI_BUS_RESET_N <= ~rst_active; // R13
            AT_BUS_RESET_OUT <= rst_active; // R13
        end
    end

    // ---------------- warm init ----------------
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) WARM_INIT_OUT <= 1'b0;
        else WARM_INIT_OUT <= SHUTDOWN_CYCLE
            || (IO_WRITE && IO_ADDR == 16'h0064 && IO_DATA == clkrst_pkg::KBD_RESET_CMD)
            || (IO_WRITE && IO_ADDR == 16'h0092 && (IO_DATA & clkrst_pkg::FAST_RESET_BIT) != 8'h00); // R14
    end

    // ---------------- power-on straps ----------------
    logic [1:0] strap_rel;
    logic strap_taken;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) strap_rel <= 2'b00;
        else strap_rel <= {strap_rel[0], 1'b1};
    end

    // pins are sampled once, by a clocked process after the reset release
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            POWER_ON_STRAP_CONFIG <= 12'h000;
            strap_taken <= 1'b0;
        end else if (strap_rel[1] && !strap_taken) begin
            strap_taken <= 1'b1; // R18
            POWER_ON_STRAP_CONFIG[clkrst_pkg::MISC_LSB +: clkrst_pkg::MISC_W] <=
                MEMORY_ADDRESS_PINS_IN[clkrst_pkg::MISC_LSB +: clkrst_pkg::MISC_W]; // R15 R16
            POWER_ON_STRAP_CONFIG[clkrst_pkg::SKEW_LSB +: clkrst_pkg::SKEW_W] <=
                MEMORY_ADDRESS_PINS_IN[clkrst_pkg::SKEW_LSB +: clkrst_pkg::SKEW_W]; // R15 R16
            POWER_ON_STRAP_CONFIG[clkrst_pkg::RSVD_LSB +: clkrst_pkg::RSVD_W] <=
                MEMORY_ADDRESS_PINS_IN[clkrst_pkg::RSVD_LSB +: clkrst_pkg::RSVD_W]; // R19
        end
    end

    // address pins float until straps are caught; the memory controller owns them afterwards
    assign MEMORY_ADDRESS_PINS_OE_N = ~strap_taken; // R17
    assign MEMORY_ADDRESS_PINS_OUT = 12'h000;

    // ---------------- checks ----------------
    sequence reset_pulse_s;
        rst_active [*8];
    endsequence

    strap_stable_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R18
        strap_taken |=> $stable(POWER_ON_STRAP_CONFIG))
        else $error("strap register changed after capture");
    pins_float_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R17
        !strap_taken |-> MEMORY_ADDRESS_PINS_OE_N)
        else $error("address pins driven before strap capture");
    pci_half_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R4
        !slow_pci && $changed(pci_clk_q) ##1 !slow_pci ##1 !slow_pci |-> $changed(pci_clk_q))
        else $error("pci base clock not half rate");
    cache_stop_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R3
        cache_stop_req && phase ##1 cache_stop_req |-> ##1 !CACHE_CLOCK_OUT)
        else $error("cache clock ran while stop requested");
    warm_kbd_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R14
        IO_WRITE && IO_ADDR == 16'h0064 && IO_DATA == clkrst_pkg::KBD_RESET_CMD |=> WARM_INIT_OUT)
        else $error("keyboard reset gave no warm init");
    reset_hold_a: assert property (@(posedge SLOW_MGMT_CLOCK) disable iff (!RESETN) // R13
        $rose(rst_active) |-> reset_pulse_s)
        else $error("reset pulse too short");
    reset_out_a: assert property (@(posedge SLOW_MGMT_CLOCK) disable iff (!RESETN) // R13
        rst_active |=> PROCESSOR_RESET_OUT && !PCI_BUS_RESET_N && AT_BUS_RESET_OUT)
        else $error("reset outputs not following pulse");
    deep_stop_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R9
        POWER_MODE == clkrst_pkg::MODE_DEEP && !general_io_pin_2_sync[1] && !serial_gate |=> !SERIAL_LINK_CLOCK)
        else $error("serial clock ran in deep sleep");
endmodule

// *** clock_reset_strap_control_test.sv ***
// self-checking bench for the clock, reset and strap controller
// assumes the peer model stands on the serial link and the slow clock runs near 32 kHz
`timescale 1ns/1ps
module clock_reset_strap_control_test;
    localparam int TICKS = 8;
    logic CORE_CLK = 1'b0, RESETN = 1'b0, SLOW_MGMT_CLOCK = 1'b0, SERIAL_LINK_CLOCK_IN = 1'b0;
    logic POWER_GOOD_IN = 1'b1, MORE_STOP = 1'b0, CACHE_IDLE = 1'b0, STOP_CLOCK_REQ_N = 1'b1;
    logic PCI_SNOOP_ACTIVE = 1'b0, PCI_BUS_IDLE = 1'b0, GENERAL_IO_PIN_2 = 1'b0;
    logic SHUTDOWN_CYCLE = 1'b0, IO_WRITE = 1'b0, peer_bit;
    logic [7:0] PCI_DIV_SEL = 8'h00, IO_DATA = 8'h00;
    logic [15:0] IO_ADDR = 16'h0000;
    logic [11:0] MEMORY_ADDRESS_PINS_IN = 12'hc6b, ma_out, strap;
    logic [3:0] peer_ev = 4'h0;
    logic [1:0] rx;
    clkrst_pkg::power_mode_t POWER_MODE = clkrst_pkg::MODE_FULL_ON;
    clkrst_pkg::pm_inputs_t pm_raw = 5'h00, pm_clean;
    clkrst_pkg::peer_info_t peer_info = 2'h0;
    clkrst_pkg::peer_events_t ev_out;
    logic ma_oe_n, cpu_clk, l2_clk, comp_clk, pci_clk, ser_clk, ser_out, tick;
    logic cpu_rst, pci_rst_n, at_rst, warm;
    int n_errors = 0, compares = 0, cycles = 0, n_cpu, n_l2, n_comp, n_pci, n_ser, n_tick;

    clock_reset_strap_control #(.PCI_IDLE_LIMIT(8), .RESET_TICKS(TICKS)) DUT (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SLOW_MGMT_CLOCK(SLOW_MGMT_CLOCK),
        .SERIAL_LINK_CLOCK_IN(SERIAL_LINK_CLOCK_IN), .POWER_GOOD_IN(POWER_GOOD_IN),
        .POWER_MODE(POWER_MODE), .MORE_STOP(MORE_STOP), .CACHE_IDLE(CACHE_IDLE),
        .STOP_CLOCK_REQ_N(STOP_CLOCK_REQ_N), .PCI_SNOOP_ACTIVE(PCI_SNOOP_ACTIVE),
        .PCI_BUS_IDLE(PCI_BUS_IDLE), .PCI_DIV_SEL(PCI_DIV_SEL), .GENERAL_IO_PIN_2(GENERAL_IO_PIN_2),
        .PM_INPUTS_RAW(pm_raw), .SHUTDOWN_CYCLE(SHUTDOWN_CYCLE), .IO_WRITE(IO_WRITE),
        .IO_ADDR(IO_ADDR), .IO_DATA(IO_DATA), .PEER_INFO(peer_info), .SERIAL_IN_FROM_PEER(peer_bit),
        .MEMORY_ADDRESS_PINS_IN(MEMORY_ADDRESS_PINS_IN), .MEMORY_ADDRESS_PINS_OUT(ma_out),
        .MEMORY_ADDRESS_PINS_OE_N(ma_oe_n), .PROCESSOR_CLOCK_OUT(cpu_clk), .CACHE_CLOCK_OUT(l2_clk),
        .COMPANION_LINK_CLOCK(comp_clk), .PCI_BUS_CLOCK(pci_clk), .SERIAL_LINK_CLOCK(ser_clk),
        .SERIAL_OUT_TO_PEER(ser_out), .PEER_EVENTS(ev_out), .PM_INPUTS_CLEAN(pm_clean),
        .SLOW_TICK(tick), .PROCESSOR_RESET_OUT(cpu_rst), .PCI_BUS_RESET_N(pci_rst_n),
        .AT_BUS_RESET_OUT(at_rst), .WARM_INIT_OUT(warm), .POWER_ON_STRAP_CONFIG(strap)
    );

    peer_io_model peer (
        .link_clk(SERIAL_LINK_CLOCK_IN), .rst_n(RESETN), .events(peer_ev),
        .from_ctrl(ser_out), .to_ctrl(peer_bit), .rx(rx)
    );

    initial forever #20 CORE_CLK = ~CORE_CLK;
    initial forever #15259 SLOW_MGMT_CLOCK = ~SLOW_MGMT_CLOCK;
    initial begin
        #7;
        forever #16 SERIAL_LINK_CLOCK_IN = ~SERIAL_LINK_CLOCK_IN;
    end

    always @(posedge cpu_clk) n_cpu++;
    always @(posedge l2_clk) n_l2++;
    always @(posedge comp_clk) n_comp++;
    always @(posedge pci_clk) n_pci++;
    always @(posedge ser_clk) n_ser++;
    always @(posedge CORE_CLK) if (tick === 1'b1) n_tick++;

    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 95000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // counts output clock edges over a window of core cycles
    task automatic window(input int n);
        @(negedge CORE_CLK);
        {n_cpu, n_l2, n_comp, n_pci, n_ser, n_tick} = '0;
        repeat (n) @(negedge CORE_CLK);
    endtask

    task automatic slow(input int n);
        repeat (n) @(posedge SLOW_MGMT_CLOCK);
        @(negedge CORE_CLK);
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [7:0] d, input logic exp);
        IO_WRITE = 1'b1;
        IO_ADDR = a;
        IO_DATA = d;
        @(negedge CORE_CLK);
        IO_WRITE = 1'b0;
        check(warm, exp);
        @(negedge CORE_CLK);
        check(warm, 1'b0);
    endtask

    task automatic resets(input logic on);
        check({cpu_rst, at_rst, pci_rst_n}, {on, on, ~on});
    endtask

    task automatic master_reset(input logic [11:0] pins);
        @(negedge CORE_CLK);
        RESETN = 1'b0;
        MEMORY_ADDRESS_PINS_IN = pins;
        repeat (20) @(negedge CORE_CLK);
        slow(2);
        check(ma_oe_n, 1'b1);
        check(strap, 12'h000);
        resets(1'b1);
        RESETN = 1'b1;
        repeat (4) @(negedge CORE_CLK);
        check(strap, pins);
        check(ma_oe_n, 1'b0);
    endtask

    initial begin
        master_reset(12'hc6b);
        check(strap[2:0], 3'h3);
        check(strap[5:3], 3'h5);
        check(strap[11:6], 6'h31);
        MEMORY_ADDRESS_PINS_IN = 12'h2d4;
        pm_raw = 5'h0d;
        window(800);
        check(strap, 12'hc6b);
        slow(TICKS + 8);
        resets(1'b0);
        check(pm_clean, 5'h0d);
        slow(1);
        window(763);
        check(n_tick, 1);
        // accepted writes one idle cycle apart, then refused ones
        io_wr(16'h0064, 8'hfe, 1'b1);
        io_wr(16'h0092, 8'h01, 1'b1);
        io_wr(16'h0064, 8'h00, 1'b0);
        io_wr(16'h0060, 8'hfe, 1'b0);
        io_wr(16'h0092, 8'hfe, 1'b0);
        SHUTDOWN_CYCLE = 1'b1;
        @(negedge CORE_CLK);
        SHUTDOWN_CYCLE = 1'b0;
        check(warm, 1'b1);
        window(64);
        check(n_cpu, 32);
        check(n_l2, 32);
        check(n_comp, 32);
        check(n_pci, 16);
        check(n_ser, 16);
        CACHE_IDLE = 1'b1;
        window(8);
        window(64);
        check(n_l2, 0);
        CACHE_IDLE = 1'b0;
        STOP_CLOCK_REQ_N = 1'b0;
        window(8);
        window(64);
        check(n_l2, 0);
        PCI_SNOOP_ACTIVE = 1'b1;
        window(8);
        window(64);
        check(n_l2, 32);
        STOP_CLOCK_REQ_N = 1'b1;
        PCI_SNOOP_ACTIVE = 1'b0;
        POWER_MODE = clkrst_pkg::MODE_SLEEP;
        window(8);
        window(64);
        check(n_cpu, 0);
        check(n_ser, 16);
        // switch activity is a primary activity and must restart the processor clock
        pm_raw = 5'h1d;
        slow(8);
        window(64);
        check(n_cpu, 32);
        POWER_MODE = clkrst_pkg::MODE_DEEP;
        window(8);
        window(64);
        check(n_ser, 0);
        POWER_MODE = clkrst_pkg::MODE_FULL_ON;
        PCI_BUS_IDLE = 1'b1;
        PCI_DIV_SEL = 8'h01;
        window(64);
        window(1024);
        check(n_pci, 128);
        PCI_BUS_IDLE = 1'b0;
        // serial link both ways with patterns that survive any slot phase
        peer_ev = 4'hf;
        peer_info = 2'h3;
        window(64);
        check(ev_out, 4'hf);
        check(rx, 2'h3);
        peer_ev = 4'h0;
        peer_info = 2'h0;
        window(64);
        check(ev_out, 4'h0);
        check(rx, 2'h0);
        POWER_GOOD_IN = 1'b0;
        slow(6);
        resets(1'b1);
        POWER_GOOD_IN = 1'b1;
        slow(TICKS - 4);
        resets(1'b1);
        slow(10);
        resets(1'b0);
        master_reset(12'h2d4);
        test_done();
    end
endmodule

// *** debounce_cell.sv ***
// one debounced management input on the 32 kHz clock
// assumes the input is asynchronous to that clock
`timescale 1ns/1ps
module debounce_cell #(
    parameter int TICKS = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic clean
);
    logic sync1;
    logic sync2;
    logic [7:0] cnt;

    initial begin
        if (TICKS < 1 || TICKS > 255) $error("debounce TICKS out of range");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    // a level must stay stable for TICKS samples before it is accepted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            clean <= 1'b0;
        end else if (sync2 == clean) begin
            cnt <= 8'h00;
        end else if (cnt == 8'(TICKS - 1)) begin
            cnt <= 8'h00;
            clean <= sync2;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// *** peer_io_model.sv ***
// far-side peer chip: serializes its event bits inbound and collects outbound bits
// assumes the link clock runs while frames flow and that it leaves reset with the controller
`timescale 1ns/1ps
module peer_io_model (
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic [3:0] events,
    input wire logic from_ctrl,
    output logic to_ctrl,
    output logic [1:0] rx
);
    logic [1:0] slot;

    // launched on the falling edge so the controller samples a settled bit
    always_ff @(negedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot <= 2'h0;
            to_ctrl <= 1'b0;
        end else begin
            to_ctrl <= events[2'h3 - slot];
            slot <= slot + 2'h1;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx <= 2'h0;
        end else begin
            rx <= {rx[0], from_ctrl};
        end
    end
endmodule
